/* rtl/ntrb_regs.svh */
// register map, field values and reset values of the transport register bank
`ifndef NTRB_REGS_SVH
`define NTRB_REGS_SVH

// byte addresses on the register bus
`define NTRB_A_VERSION    32'h0000_0000
`define NTRB_A_MODE       32'h0000_0004
`define NTRB_A_HWADDR_HI  32'h0000_0008
`define NTRB_A_HWADDR_LO  32'h0000_000C
`define NTRB_A_SUPPORT    32'h0000_0010
`define NTRB_A_SELECT     32'h0000_0014
`define NTRB_A_ACT_IP     32'h0000_0024
`define NTRB_A_ACT_MASK   32'h0000_0034
`define NTRB_A_ACT_GW     32'h0000_0044
`define NTRB_A_URL1       32'h0000_0200
`define NTRB_A_URL2       32'h0000_0400
`define NTRB_A_IFCOUNT    32'h0000_0600
`define NTRB_A_STO_IP     32'h0000_064C
`define NTRB_A_STO_MASK   32'h0000_065C
`define NTRB_A_STO_GW     32'h0000_066C
`define NTRB_A_MSGCH      32'h0000_0900
`define NTRB_A_STRCH      32'h0000_0904
`define NTRB_A_PAYLOAD    32'hA000_0120
`define NTRB_A_STATUS     32'hA000_0194
`define NTRB_A_SPEED      32'hA000_0198
`define NTRB_A_IFSEL      32'hA000_01A0

// string regions: 512 bytes each, first 32 bytes carry text
`define NTRB_URL_MASK     32'hFFFF_FE00
`define NTRB_URL_IDX      8:2
`define NTRB_URL_WORDS    7'h08

// constant field values
`define NTRB_VER_MAJOR    16'h0001
`define NTRB_VER_MINOR    16'h0000
`define NTRB_BIG_ENDIAN   1'h0
`define NTRB_CHARSET_UTF8 8'h01
`define NTRB_SUPPORT      32'h0000_0007
`define NTRB_IFCOUNT      32'h0000_0001
`define NTRB_MSGCH        32'h0000_0000
`define NTRB_STRCH        32'h0000_0001
`define NTRB_IFSEL        32'h0000_0000
`define NTRB_SPEED_MAX    32'h0000_03E8

// reset values
`define NTRB_SEL_RESET    3'h6
`define NTRB_STO_RESET    32'h0000_0000

`endif

/* rtl/ntrb_pkg.sv */
// types shared by the transport register bank
package ntrb_pkg;

  typedef struct packed {
    logic [15:0] major;
    logic [15:0] minor;
  } ntrb_version_t;

  typedef struct packed {
    logic        big_endian;
    logic [22:0] rsvd;
    logic [7:0]  charset;
  } ntrb_mode_t;

  typedef struct packed {
    logic [28:0] rsvd;
    logic        link_local;
    logic        dhcp;
    logic        stat;
  } ntrb_ipcfg_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] gw;
  } ntrb_ipv4_set_t;

  typedef enum logic [2:0] {
    NTRB_ST_NONE      = 3'h0,
    NTRB_ST_STORED    = 3'h1,
    NTRB_ST_DHCP      = 3'h2,
    NTRB_ST_LINKLOCAL = 3'h3,
    NTRB_ST_FORCED    = 3'h4
  } ntrb_ipstat_t;

endpackage

/* rtl/ntrb_top.sv */
// transport register bank: APB slave with version, addressing and link registers
`timescale 1ns/1ps
`include "ntrb_regs.svh"

module ntrb_top #(
  parameter logic [255:0] URL_FIRST  = "local:device.xml;0;0",
  parameter logic [255:0] URL_SECOND = "local:device.xml;0;0"
) (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [47:0]             hw_address,
  input  wire ntrb_pkg::ntrb_ipv4_set_t dhcp_lease,
  input  wire ntrb_pkg::ntrb_ipv4_set_t link_local_lease,
  input  wire ntrb_pkg::ntrb_ipv4_set_t forced_lease,
  input  wire logic [31:0]             link_speed_in,
  input  wire logic [31:0]             payload_size_in,
  output logic                         dhcp_enable,
  output logic                         stored_enable
);

  // strings are left-justified so that byte 0 is the first character
  function automatic logic [255:0] ntrb_just(input logic [255:0] s);
    logic [255:0] t;
    t = s;
    for (int i = 0; i < 32; i++) begin
      if (t[255:248] == 8'h00) begin
        t = t << 8;
      end
    end
    return t;
  endfunction

  // one word of a string region, bytes little endian
  function automatic logic [31:0] ntrb_url_word(input logic [255:0] s,
                                                input logic [6:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx < `NTRB_URL_WORDS) begin
      for (int b = 0; b < 4; b++) begin
        w[8*b +: 8] = s[255 - 8*(4*idx + b) -: 8];
      end
    end
    return w;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] ntrb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return m;
  endfunction

  localparam logic [255:0] URL1_J = ntrb_just(URL_FIRST);
  localparam logic [255:0] URL2_J = ntrb_just(URL_SECOND);

  // state
  ntrb_pkg::ntrb_ipcfg_t  sel_reg;
  ntrb_pkg::ntrb_ipcfg_t  sel_next;
  logic [31:0]            sto_ip_reg;
  logic [31:0]            sto_mask_reg;
  logic [31:0]            sto_gw_reg;
  logic [31:0]            act_ip_reg;
  logic [31:0]            act_mask_reg;
  logic [31:0]            act_gw_reg;
  ntrb_pkg::ntrb_ipstat_t status_reg;
  ntrb_pkg::ntrb_ipstat_t status_next;
  ntrb_pkg::ntrb_ipv4_set_t act_next;
  logic [31:0]            speed_reg;
  logic [31:0]            payload_reg;
  logic [31:0]            prdata_reg;
  logic                   err_reg;

  // bus phases
  wire setup_ph = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite & pready;

  // address decode
  wire hit_ver     = paddr == `NTRB_A_VERSION;
  wire hit_mode    = paddr == `NTRB_A_MODE;
  wire hit_mac_hi  = paddr == `NTRB_A_HWADDR_HI;
  wire hit_mac_lo  = paddr == `NTRB_A_HWADDR_LO;
  wire hit_sup     = paddr == `NTRB_A_SUPPORT;
  wire hit_sel     = paddr == `NTRB_A_SELECT;
  wire hit_aip     = paddr == `NTRB_A_ACT_IP;
  wire hit_amask   = paddr == `NTRB_A_ACT_MASK;
  wire hit_agw     = paddr == `NTRB_A_ACT_GW;
  wire hit_url1    = (paddr & `NTRB_URL_MASK) == `NTRB_A_URL1;
  wire hit_url2    = (paddr & `NTRB_URL_MASK) == `NTRB_A_URL2;
  wire hit_ifc     = paddr == `NTRB_A_IFCOUNT;
  wire hit_sip     = paddr == `NTRB_A_STO_IP;
  wire hit_smask   = paddr == `NTRB_A_STO_MASK;
  wire hit_sgw     = paddr == `NTRB_A_STO_GW;
  wire hit_msg     = paddr == `NTRB_A_MSGCH;
  wire hit_str     = paddr == `NTRB_A_STRCH;
  wire hit_pay     = paddr == `NTRB_A_PAYLOAD;
  wire hit_stat    = paddr == `NTRB_A_STATUS;
  wire hit_spd     = paddr == `NTRB_A_SPEED;
  wire hit_ifsel   = paddr == `NTRB_A_IFSEL;

  wire hit_any = hit_ver | hit_mode | hit_mac_hi | hit_mac_lo | hit_sup |
                 hit_sel | hit_aip | hit_amask | hit_agw | hit_url1 |
                 hit_url2 | hit_ifc | hit_sip | hit_smask | hit_sgw |
                 hit_msg | hit_str | hit_pay | hit_stat | hit_spd | hit_ifsel;

  // constant words
  wire ntrb_pkg::ntrb_version_t ver_w = '{major: `NTRB_VER_MAJOR,
                                          minor: `NTRB_VER_MINOR};
  wire ntrb_pkg::ntrb_mode_t mode_w = '{big_endian: `NTRB_BIG_ENDIAN,
                                        rsvd: '0,
                                        charset: `NTRB_CHARSET_UTF8};

  // url windows; only the word index inside the region matters
  wire [6:0]  url_idx = paddr[`NTRB_URL_IDX];
  wire [31:0] url1_w  = ntrb_url_word(URL1_J, url_idx);
  wire [31:0] url2_w  = ntrb_url_word(URL2_J, url_idx);

  // read selection, and-or so unmapped reads come out zero
  wire [31:0] rd_word =
      ({32{hit_ver}}    & ver_w)                                  |
      ({32{hit_mode}}   & mode_w)                                 |
      ({32{hit_mac_hi}} & {16'h0000, hw_address[47:32]})          |
      ({32{hit_mac_lo}} & hw_address[31:0])                      |
      ({32{hit_sup}}    & `NTRB_SUPPORT)                          |
      ({32{hit_sel}}    & sel_reg)                                |
      ({32{hit_aip}}    & act_ip_reg)                             |
      ({32{hit_amask}}  & act_mask_reg)                           |
      ({32{hit_agw}}    & act_gw_reg)                             |
      ({32{hit_url1}}   & url1_w)                                 |
      ({32{hit_url2}}   & url2_w)                                 |
      ({32{hit_ifc}}    & `NTRB_IFCOUNT)                          |
      ({32{hit_sip}}    & sto_ip_reg)                             |
      ({32{hit_smask}}  & sto_mask_reg)                           |
      ({32{hit_sgw}}    & sto_gw_reg)                             |
      ({32{hit_msg}}    & `NTRB_MSGCH)                            |
      ({32{hit_str}}    & `NTRB_STRCH)                            |
      ({32{hit_pay}}    & payload_reg)                            |
      ({32{hit_stat}}   & {29'h0000_0000, status_reg})            |
      ({32{hit_spd}}    & speed_reg)                              |
      ({32{hit_ifsel}}  & `NTRB_IFSEL);

  // select register: only two enables take writes, link-local stays set
  wire [31:0] sel_wd = ntrb_merge(sel_reg, pwdata, pstrb);
  always_comb begin
    sel_next = sel_reg;
    if (wr_acc && hit_sel) begin
      sel_next.dhcp = sel_wd[1];
      sel_next.stat = sel_wd[0];
    end
    sel_next.link_local = 1'b1;
    sel_next.rsvd = '0;
  end

  // which lease becomes active; forced wins, then stored, then dhcp
  always_comb begin
    act_next    = '0;
    status_next = ntrb_pkg::NTRB_ST_NONE;
    if (forced_lease.valid) begin
      act_next    = forced_lease;
      status_next = ntrb_pkg::NTRB_ST_FORCED;
    end else if (sel_reg.stat) begin
      act_next    = '{valid: 1'b1, ip: sto_ip_reg, mask: sto_mask_reg,
                      gw: sto_gw_reg};
      status_next = ntrb_pkg::NTRB_ST_STORED;
    end else if (sel_reg.dhcp && dhcp_lease.valid) begin
      act_next    = dhcp_lease;
      status_next = ntrb_pkg::NTRB_ST_DHCP;
    end else if (link_local_lease.valid) begin
      act_next    = link_local_lease;
      status_next = ntrb_pkg::NTRB_ST_LINKLOCAL;
    end
  end

  // speed above the top figure is clipped, not passed through
  wire [31:0] speed_next = (link_speed_in > `NTRB_SPEED_MAX) ?
                           `NTRB_SPEED_MAX : link_speed_in;

  // software-written registers; every other address ignores the write
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sel_reg      <= ntrb_pkg::ntrb_ipcfg_t'({29'h0000_0000, `NTRB_SEL_RESET});
      sto_ip_reg   <= `NTRB_STO_RESET;
      sto_mask_reg <= `NTRB_STO_RESET;
      sto_gw_reg   <= `NTRB_STO_RESET;
    end else begin
      sel_reg <= sel_next;
      if (wr_acc && hit_sip) begin
        sto_ip_reg <= ntrb_merge(sto_ip_reg, pwdata, pstrb);
      end
      if (wr_acc && hit_smask) begin
        sto_mask_reg <= ntrb_merge(sto_mask_reg, pwdata, pstrb);
      end
      if (wr_acc && hit_sgw) begin
        sto_gw_reg <= ntrb_merge(sto_gw_reg, pwdata, pstrb);
      end
    end
  end

  // status follows the leases one cycle later
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status_reg   <= ntrb_pkg::NTRB_ST_NONE;
      act_ip_reg   <= `NTRB_STO_RESET;
      act_mask_reg <= `NTRB_STO_RESET;
      act_gw_reg   <= `NTRB_STO_RESET;
      speed_reg    <= `NTRB_STO_RESET;
      payload_reg  <= `NTRB_STO_RESET;
    end else begin
      status_reg   <= status_next;
      act_ip_reg   <= act_next.ip;
      act_mask_reg <= act_next.mask;
      act_gw_reg   <= act_next.gw;
      speed_reg    <= speed_next;
      payload_reg  <= payload_size_in;
    end
  end

  // read data is caught in setup so prdata comes from a flop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
      err_reg    <= ~hit_any;
    end
  end

  // zero wait states; error only for an unmapped address
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & err_reg;
  assign prdata        = prdata_reg;
  assign dhcp_enable   = sel_reg.dhcp;
  assign stored_enable = sel_reg.stat;

  // checks
  wire rd_set = psel & ~penable & ~pwrite;

  AST_VERSION_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_VERSION |=> prdata == 32'h0001_0000)
    else $error("version word wrong");

  AST_MODE_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_MODE |=> prdata[31] == 1'b0 && prdata[7:0] == 8'h01)
    else $error("device mode word wrong");

  AST_MAC_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_HWADDR_LO |=> prdata == $past(hw_address[31:0]))
    else $error("hardware address low word wrong");

  AST_SUPPORT_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_SUPPORT |=> prdata[2:0] == 3'h7)
    else $error("supported addressing wrong");

  AST_FORCED_STATUS: assert property (@(posedge clk_sys) disable iff (!resetn)
    // sampled resetn keeps the release edge, with state still in reset, out
    resetn && forced_lease.valid |=> status_reg == ntrb_pkg::NTRB_ST_FORCED
                           && act_ip_reg == $past(forced_lease.ip))
    else $error("forced lease not reported");

  AST_SELECT_STORED: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && hit_sel && pstrb[0] && pwdata[2:0] == 3'h5
    |=> stored_enable && !dhcp_enable ##1 (forced_lease.valid
        || status_reg == ntrb_pkg::NTRB_ST_STORED))
    else $error("write of 5 did not pick stored addressing");

  AST_LINKLOCAL_ON: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 sel_reg.link_local == 1'b1 && sel_reg.rsvd == '0)
    else $error("link-local enable not held");

  AST_STORED_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && hit_sip && pstrb == 4'hF |=> sto_ip_reg == $past(pwdata))
    else $error("stored address not written");

  AST_SPEED_RANGE: assert property (@(posedge clk_sys) disable iff (!resetn)
    speed_reg <= `NTRB_SPEED_MAX)
    else $error("link speed out of range");

  AST_COUNTS_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_STRCH |=> prdata == 32'h0000_0001)
    else $error("stream channel count wrong");

  AST_MSG_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_MSGCH |=> prdata == 32'h0000_0000)
    else $error("message channel count wrong");

  AST_RO_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && !hit_sel && !hit_sip && !hit_smask && !hit_sgw
    |=> $stable(sel_reg) && $stable(sto_ip_reg) && $stable(sto_mask_reg)
        && $stable(sto_gw_reg))
    else $error("read-only write changed state");

  AST_IFSEL_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_IFSEL |=> prdata == `NTRB_IFSEL)
    else $error("interface selector not zero");

  AST_IFCOUNT_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_IFCOUNT |=> prdata == `NTRB_IFCOUNT)
    else $error("interface count wrong");

  AST_PAYLOAD_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_PAYLOAD |=> prdata == $past(payload_size_in, 2))
    else $error("payload size wrong");

  AST_HWADDR_HI: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && paddr == `NTRB_A_HWADDR_HI |=> prdata == {16'h0000, $past(hw_address[47:32])})
    else $error("hardware address high word wrong");

  AST_URL_TAIL: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && (hit_url1 || hit_url2) && url_idx >= `NTRB_URL_WORDS |=> prdata == 32'h0000_0000)
    else $error("string region tail not zero");

  AST_SELECT_DHCP: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && hit_sel && pstrb[0] && pwdata[2:0] == 3'h6
    |=> dhcp_enable && !stored_enable)
    else $error("write of 6 did not pick dhcp");

  AST_STATUS_DHCP: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && !forced_lease.valid && !stored_enable && dhcp_enable && dhcp_lease.valid
    |=> status_reg == ntrb_pkg::NTRB_ST_DHCP)
    else $error("dhcp lease not reported");

  AST_MASK_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && hit_smask |=> sto_mask_reg[7:0] ==
        ($past(pstrb[0]) ? $past(pwdata[7:0]) : $past(sto_mask_reg[7:0])))
    else $error("stored mask byte lane wrong");

  COV_SELECT_DHCP: cover property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && hit_sel && pwdata[2:0] == 3'h6);

  COV_URL_READ: cover property (@(posedge clk_sys) disable iff (!resetn)
    rd_set && hit_url1 ##1 prdata != 32'h0000_0000);

  COV_UNMAPPED: cover property (@(posedge clk_sys) disable iff (!resetn)
    pslverr);

  COV_FORCED: cover property (@(posedge clk_sys) disable iff (!resetn)
    status_reg == ntrb_pkg::NTRB_ST_FORCED);

  COV_PARTIAL_STROBE: cover property (@(posedge clk_sys) disable iff (!resetn)
    wr_acc && hit_smask && pstrb != 4'hF);

endmodule

/* bench/ntrb_host_model.sv */
// host side model: register bus master used by the bench
`timescale 1ns/1ps

module ntrb_host_model (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // one transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no limit here; the bench watchdog ends a stuck run
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // host selects addressing by plain register writes
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, 4'hF, q, e);
  endtask

  // write with chosen byte lanes
  task automatic wrs(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, s, q, e);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, ~a, 4'h0, q, e);
  endtask
endmodule

/* bench/ntrb_testbench.sv */
// self-checking bench of the transport register bank
`timescale 1ns/1ps
`include "ntrb_regs.svh"

module testbench;
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] x;} ntrb_tb_row_t;
  logic                     clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic                     dhcp_enable, stored_enable, e;
  logic [31:0]              paddr, pwdata, prdata, link_speed_in, payload_size_in, q;
  logic [3:0]               pstrb;
  logic [47:0]              hw_address;
  ntrb_pkg::ntrb_ipv4_set_t dhcp_lease, link_local_lease, forced_lease;
  int                       err_count, n_tests;
  ntrb_tb_row_t             rows[19];
  logic [31:0]              sw[4], sx[4], st[4], sip[4];

  ntrb_top #(
    .URL_FIRST  ("abcdefghijklmnopqrstuvwxyz012345"),
    .URL_SECOND ("ABCDEFGHIJKLMNOPQRSTUVWXYZ012345")
  ) uut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_address(hw_address),
    .dhcp_lease(dhcp_lease), .link_local_lease(link_local_lease),
    .forced_lease(forced_lease), .link_speed_in(link_speed_in),
    .payload_size_in(payload_size_in), .dhcp_enable(dhcp_enable),
    .stored_enable(stored_enable));

  ntrb_host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // clock
  always #20 clk_sys = ~clk_sys;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic results;
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    err_count++;
    results();
  end

  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    err_count = 0;
    n_tests = 0;
    hw_address = 48'h0123_4567_89AB;
    link_speed_in = 32'h0000_0064;
    payload_size_in = 32'h0000_1000;
    dhcp_lease = '{1'b0, 32'hC0A8_0005, 32'hFFFF_FF00, 32'hC0A8_0001};
    link_local_lease = '{1'b0, 32'hA9FE_0007, 32'hFFFF_0000, 32'h0000_0000};
    forced_lease = '{1'b0, 32'h0A0A_0A0A, 32'hFF00_0000, 32'h0A0A_0A01};
    // all-ones writes (zero to the support word) to read-only words must not stick
    rows = '{
      '{`NTRB_A_VERSION, 32'hFFFF_FFFF, 32'h0001_0000},
      '{`NTRB_A_MODE, 32'hFFFF_FFFF, 32'h0000_0001},
      '{`NTRB_A_HWADDR_HI, 32'hFFFF_FFFF, 32'h0000_0123},
      '{`NTRB_A_HWADDR_LO, 32'hFFFF_FFFF, 32'h4567_89AB},
      '{`NTRB_A_SUPPORT, 32'h0000_0000, 32'h0000_0007},
      '{`NTRB_A_IFCOUNT, 32'hFFFF_FFFF, 32'h0000_0001},
      '{`NTRB_A_MSGCH, 32'hFFFF_FFFF, 32'h0000_0000},
      '{`NTRB_A_STRCH, 32'hFFFF_FFFF, 32'h0000_0001},
      '{`NTRB_A_IFSEL, 32'hFFFF_FFFF, 32'h0000_0000},
      '{`NTRB_A_SPEED, 32'hFFFF_FFFF, 32'h0000_0064},
      '{`NTRB_A_PAYLOAD, 32'hFFFF_FFFF, 32'h0000_1000},
      '{`NTRB_A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000},
      '{`NTRB_A_ACT_IP, 32'hFFFF_FFFF, 32'h0000_0000},
      '{`NTRB_A_URL1, 32'hFFFF_FFFF, 32'h6463_6261},
      '{`NTRB_A_URL2, 32'hFFFF_FFFF, 32'h4443_4241},
      '{32'h0000_0220, 32'hFFFF_FFFF, 32'h0000_0000},
      '{`NTRB_A_STO_IP, 32'h0A00_0002, 32'h0A00_0002},
      '{`NTRB_A_STO_MASK, 32'hFFFF_FF00, 32'hFFFF_FF00},
      '{`NTRB_A_STO_GW, 32'h0A00_0001, 32'h0A00_0001}};
    sw = '{32'h0000_0005, 32'h0000_0006, 32'h0000_0004, 32'h0000_0000};
    sx = '{32'h0000_0005, 32'h0000_0006, 32'h0000_0004, 32'h0000_0004};
    st = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0003, 32'h0000_0003};
    sip = '{32'h0A00_0002, 32'hC0A8_0005, 32'hA9FE_0007, 32'hA9FE_0007};
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    chk1(dhcp_enable, 1'b1);
    chk1(stored_enable, 1'b0);
    // ordinary cases: write, then read back
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, q, e);
      chk32(q, rows[i].x);
      chk1(e, 1'b0);
    end
    // partial strobe: only byte 0 of the stored mask may change
    host.wrs(`NTRB_A_STO_MASK, 32'h1234_5678, 4'h1);
    host.rd(`NTRB_A_STO_MASK, q, e);
    chk32(q, 32'hFFFF_FF78);
    // stored, dhcp and neither selected, with the dhcp and link-local leases offered
    @(posedge clk_sys);
    dhcp_lease.valid <= 1'b1;
    link_local_lease.valid <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.wr(`NTRB_A_SELECT, sw[i]);
      host.rd(`NTRB_A_SELECT, q, e);
      chk32(q, sx[i]);
      chk1(stored_enable, sx[i][0]);
      chk1(dhcp_enable, sx[i][1]);
      host.rd(`NTRB_A_STATUS, q, e);
      chk32(q, st[i]);
      host.rd(`NTRB_A_ACT_IP, q, e);
      chk32(q, sip[i]);
    end
    // forced address wins, writes to status ignored
    @(posedge clk_sys);
    forced_lease.valid <= 1'b1;
    link_speed_in <= 32'h0000_07D0;
    host.wr(`NTRB_A_STATUS, 32'h0000_0000);
    host.rd(`NTRB_A_STATUS, q, e);
    chk32(q, 32'h0000_0004);
    host.rd(`NTRB_A_ACT_GW, q, e);
    chk32(q, 32'h0A0A_0A01);
    host.rd(`NTRB_A_ACT_MASK, q, e);
    chk32(q, 32'hFF00_0000);
    host.rd(`NTRB_A_SPEED, q, e);
    chk32(q, `NTRB_SPEED_MAX);
    // unmapped place answers with an error and zero
    host.rd(32'h0000_0100, q, e);
    chk32(q, 32'h0000_0000);
    chk1(e, 1'b1);
    // reset in mid-run restores select and stored values
    host.wr(`NTRB_A_SELECT, 32'h0000_0005);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    host.rd(`NTRB_A_SELECT, q, e);
    chk32(q, {29'h0, `NTRB_SEL_RESET});
    host.rd(`NTRB_A_STO_IP, q, e);
    chk32(q, `NTRB_STO_RESET);
    chk1(dhcp_enable, 1'b1);
    results();
  end
endmodule
